// ---- vrd_pkg.sv ----
// constants, types and register map of the speaker volume and reset-domain block
// Summary of operation
// - volume registers accept every byte value
// - right and left volumes independent, adjacent
// - both volumes start at minimum
// - full reset initializes every controller register
// - soft class: soft bit, enabled switch (power-on is full class)
// - switch with enable cleared retains everything
// - power bit written zero while set: power-off class
// - rtc counters, status, alarm: full only
// - touch control and data: all but retention
// - touch calibration cleared on full only
// - key registers cleared except on retention
// - shared flags cleared except on retention
// - volumes cleared except on retention
package vrd_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // printed offsets are word indices, so each sits at four times its index
    localparam logic [11:0] VOL_RIGHT_IDX  = 12'h0D0;
    localparam logic [11:0] VOL_LEFT_IDX   = 12'h0D1;
    localparam logic [11:0] RSTCTL_IDX     = 12'h0A0;
    localparam logic [11:0] SYSPWR_IDX     = 12'h0A1;
    localparam logic [11:0] RSTSTAT_IDX    = 12'h0A2;
    localparam logic [11:0] VOL_RIGHT_ADDR = {VOL_RIGHT_IDX[9:0], 2'b00};
    localparam logic [11:0] VOL_LEFT_ADDR  = {VOL_LEFT_IDX[9:0], 2'b00};
    localparam logic [11:0] RSTCTL_ADDR    = {RSTCTL_IDX[9:0], 2'b00};
    localparam logic [11:0] SYSPWR_ADDR    = {SYSPWR_IDX[9:0], 2'b00};
    localparam logic [11:0] RSTSTAT_ADDR   = {RSTSTAT_IDX[9:0], 2'b00};

    localparam logic [7:0]  VOL_RESET      = 8'h00;
    localparam logic [7:0]  VOL_MIN        = 8'h00;
    localparam logic [7:0]  VOL_MAX        = 8'hFF;

    localparam int          SOFT_RESET_BIT = 0;
    localparam int          SWITCH_EN_BIT  = 1;
    localparam int          POWER_ON_BIT   = 0;
    localparam logic        SWITCH_EN_RESET = 1'b0;
    localparam logic        POWER_ON_RESET  = 1'b1;

    localparam int          SYNC_STAGES    = 2;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [2:0] {
        CLS_NONE   = 3'b000,
        CLS_FULL   = 3'b001,
        CLS_SOFT   = 3'b010,
        CLS_POFF   = 3'b011,
        CLS_RETAIN = 3'b100
    } vrd_class_type;

endpackage : vrd_pkg

// ---- vrd_sync.sv ----
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module vrd_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    import vrd_pkg::*;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic [SYNC_STAGES-1:0] stage;
            // first stage feeds only the second
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    stage <= '0;
                end else begin
                    stage <= {stage[SYNC_STAGES-2:0], i_async[g]};
                end
            end
            assign o_sync[g] = stage[SYNC_STAGES-1];
        end
    endgenerate

endmodule : vrd_sync

// ---- vrd_axil_slave.sv ----
// axi4-lite slave front end: one write and one read outstanding
`timescale 1ns/1ns
module vrd_axil_slave (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  wire logic [vrd_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                      i_awvalid,
    output logic                           o_awready,
    input  wire logic [vrd_pkg::DATA_W-1:0] i_wdata,
    input  wire logic [3:0]                i_wstrb,
    input  wire logic                      i_wvalid,
    output logic                           o_wready,
    output logic [1:0]                     o_bresp,
    output logic                           o_bvalid,
    input  wire logic                      i_bready,
    input  wire logic [vrd_pkg::ADDR_W-1:0] i_araddr,
    input  wire logic                      i_arvalid,
    output logic                           o_arready,
    output logic [vrd_pkg::DATA_W-1:0]     o_rdata,
    output logic [1:0]                     o_rresp,
    output logic                           o_rvalid,
    input  wire logic                      i_rready,
    output logic                           o_wr_en,
    output logic [vrd_pkg::ADDR_W-1:0]     o_wr_addr,
    output logic [vrd_pkg::DATA_W-1:0]     o_wr_data,
    output logic [3:0]                     o_wr_strb,
    input  wire logic                      i_wr_ok,
    output logic [vrd_pkg::ADDR_W-1:0]     o_rd_addr,
    input  wire logic [vrd_pkg::DATA_W-1:0] i_rd_data,
    input  wire logic                      i_rd_ok
);
    import vrd_pkg::*;

    wire aw_hs = i_awvalid & o_awready;
    wire w_hs  = i_wvalid & o_wready;
    wire b_hs  = o_bvalid & i_bready;
    wire ar_hs = i_arvalid & o_arready;
    wire r_hs  = o_rvalid & i_rready;

    // both halves held and no response pending: commit once
    assign o_wr_en   = ~o_awready & ~o_wready & ~o_bvalid;
    assign o_rd_addr = i_araddr;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
            o_wr_addr <= '0;
            o_wr_data <= '0;
            o_wr_strb <= '0;
        end else begin
            if (aw_hs) begin
                o_awready <= 1'b0;
                o_wr_addr <= i_awaddr;
            end
            if (w_hs) begin
                o_wready  <= 1'b0;
                o_wr_data <= i_wdata;
                o_wr_strb <= i_wstrb;
            end
            if (o_wr_en) begin
                o_bvalid <= 1'b1;
                o_bresp  <= i_wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_hs) begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= RESP_OKAY;
        end else if (ar_hs) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= i_rd_data;
            o_rresp   <= i_rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (r_hs) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

endmodule : vrd_axil_slave

// ---- vrd_top.sv ----
// speaker volume registers and reset-class arbiter for the supply controller
`timescale 1ns/1ns
module vrd_top (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_hard_reset_switch,
    input  wire logic                       i_reset_switch,
    input  wire logic [vrd_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                       i_awvalid,
    output logic                            o_awready,
    input  wire logic [vrd_pkg::DATA_W-1:0] i_wdata,
    input  wire logic [3:0]                 i_wstrb,
    input  wire logic                       i_wvalid,
    output logic                            o_wready,
    output logic [1:0]                      o_bresp,
    output logic                            o_bvalid,
    input  wire logic                       i_bready,
    input  wire logic [vrd_pkg::ADDR_W-1:0] i_araddr,
    input  wire logic                       i_arvalid,
    output logic                            o_arready,
    output logic [vrd_pkg::DATA_W-1:0]      o_rdata,
    output logic [1:0]                      o_rresp,
    output logic                            o_rvalid,
    input  wire logic                       i_rready,
    output logic [7:0]                      o_right_speaker_volume,
    output logic [7:0]                      o_left_speaker_volume,
    output logic                            o_system_power_on,
    output logic                            o_clear_full_only,
    output logic                            o_clear_common,
    output vrd_pkg::vrd_class_type          o_applied_class
);
    import vrd_pkg::*;

    logic [1:0]              sw_sync;
    logic [1:0]              sw_prev;
    logic                    switch_reset_enable_bit;
    vrd_class_type           last_class;
    vrd_class_type           next_class;
    logic                    wr_en;
    logic [ADDR_W-1:0]       wr_addr;
    logic [DATA_W-1:0]       wr_data;
    logic [3:0]              wr_strb;
    logic [ADDR_W-1:0]       rd_addr;
    logic [DATA_W-1:0]       rd_data;
    logic                    rd_ok;
    logic                    wr_ok;

    vrd_axil_slave u_bus (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_awaddr  (i_awaddr),
        .i_awvalid (i_awvalid),
        .o_awready (o_awready),
        .i_wdata   (i_wdata),
        .i_wstrb   (i_wstrb),
        .i_wvalid  (i_wvalid),
        .o_wready  (o_wready),
        .o_bresp   (o_bresp),
        .o_bvalid  (o_bvalid),
        .i_bready  (i_bready),
        .i_araddr  (i_araddr),
        .i_arvalid (i_arvalid),
        .o_arready (o_arready),
        .o_rdata   (o_rdata),
        .o_rresp   (o_rresp),
        .o_rvalid  (o_rvalid),
        .i_rready  (i_rready),
        .o_wr_en   (wr_en),
        .o_wr_addr (wr_addr),
        .o_wr_data (wr_data),
        .o_wr_strb (wr_strb),
        .i_wr_ok   (wr_ok),
        .o_rd_addr (rd_addr),
        .i_rd_data (rd_data),
        .i_rd_ok   (rd_ok)
    );

    // switches are mechanical pins, so they cross into the clock domain first
    vrd_sync #(
        .WIDTH (2)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async ({i_hard_reset_switch, i_reset_switch}),
        .o_sync  (sw_sync)
    );

    // address decode; only byte lane 0 carries register data
    wire hit_right   = (wr_addr == VOL_RIGHT_ADDR);
    wire hit_left    = (wr_addr == VOL_LEFT_ADDR);
    wire hit_rstctl  = (wr_addr == RSTCTL_ADDR);
    wire hit_syspwr  = (wr_addr == SYSPWR_ADDR);
    wire hit_rststat = (wr_addr == RSTSTAT_ADDR);
    assign wr_ok = hit_right | hit_left | hit_rstctl | hit_syspwr | hit_rststat;

    wire lane0       = wr_en & wr_strb[0];
    wire wr_right    = lane0 & hit_right;
    wire wr_left     = lane0 & hit_left;
    wire wr_rstctl   = lane0 & hit_rstctl;
    wire wr_syspwr   = lane0 & hit_syspwr;

    // press detection on the synchronised levels
    wire hard_rise   = sw_sync[1] & ~sw_prev[1];
    wire switch_rise = sw_sync[0] & ~sw_prev[0];

    wire soft_req    = wr_rstctl & wr_data[SOFT_RESET_BIT];
    wire soft_ev     = soft_req | (switch_rise & switch_reset_enable_bit);
    wire retain_ev   = switch_rise & ~switch_reset_enable_bit;
    // power-off on a falling power bit
    wire poff_ev     = wr_syspwr & ~wr_data[POWER_ON_BIT] & o_system_power_on;
    wire full_ev     = hard_rise;

    assign next_class = full_ev   ? CLS_FULL :
                        soft_ev   ? CLS_SOFT :
                        poff_ev   ? CLS_POFF :
                        retain_ev ? CLS_RETAIN : CLS_NONE;

    wire clr_common_ev = (next_class == CLS_FULL) | (next_class == CLS_SOFT) |
                         (next_class == CLS_POFF);
    wire clr_full_ev   = (next_class == CLS_FULL);

    // power-on is the asynchronous reset and counts as full class
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sw_prev           <= 2'h0;
            o_applied_class   <= CLS_FULL;
            o_clear_full_only <= 1'b1;
            o_clear_common    <= 1'b1;
        end else begin
            sw_prev           <= sw_sync;
            o_applied_class   <= next_class;
            o_clear_full_only <= clr_full_ev;
            o_clear_common    <= clr_common_ev;
        end
    end

    // every class, retention included, stays readable until the next event
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_class <= CLS_FULL;
        end else if (next_class != CLS_NONE) begin
            last_class <= next_class;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_right_speaker_volume <= VOL_RESET;
            o_left_speaker_volume  <= VOL_RESET;
        end else if (clr_common_ev) begin
            o_right_speaker_volume <= VOL_RESET;
            o_left_speaker_volume  <= VOL_RESET;
        end else begin
            if (wr_right) begin
                o_right_speaker_volume <= wr_data[7:0];
            end
            if (wr_left) begin
                o_left_speaker_volume <= wr_data[7:0];
            end
        end
    end

    // soft request bit is not stored: the reset it causes clears it anyway
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            switch_reset_enable_bit <= SWITCH_EN_RESET;
        end else if (clr_common_ev) begin
            switch_reset_enable_bit <= SWITCH_EN_RESET;
        end else if (wr_rstctl) begin
            switch_reset_enable_bit <= wr_data[SWITCH_EN_BIT];
        end
    end

    // power bit: full and soft restore it, power-off leaves it low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_system_power_on <= POWER_ON_RESET;
        end else if (clr_full_ev || next_class == CLS_SOFT) begin
            o_system_power_on <= POWER_ON_RESET;
        end else if (wr_syspwr) begin
            o_system_power_on <= wr_data[POWER_ON_BIT];
        end
    end

    // read mux; unmapped words answer with an error and zero data
    wire rd_right   = (rd_addr == VOL_RIGHT_ADDR);
    wire rd_left    = (rd_addr == VOL_LEFT_ADDR);
    wire rd_rstctl  = (rd_addr == RSTCTL_ADDR);
    wire rd_syspwr  = (rd_addr == SYSPWR_ADDR);
    wire rd_rststat = (rd_addr == RSTSTAT_ADDR);
    assign rd_ok = rd_right | rd_left | rd_rstctl | rd_syspwr | rd_rststat;

    wire [DATA_W-1:0] rd_rstctl_word = {30'h0000_0000, switch_reset_enable_bit, 1'b0};
    assign rd_data = rd_right   ? {24'h00_0000, o_right_speaker_volume} :
                     rd_left    ? {24'h00_0000, o_left_speaker_volume}  :
                     rd_rstctl  ? rd_rstctl_word                        :
                     rd_syspwr  ? {31'h0000_0000, o_system_power_on}    :
                     rd_rststat ? {29'h0000_0000, last_class}           :
                                  32'h0000_0000;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_vol_any_byte;
        wr_right && !clr_common_ev |=> o_right_speaker_volume == $past(wr_data[7:0]);
    endproperty
    a_vol_any_byte: assert property (p_vol_any_byte) else $error("right volume not stored");

    property p_vol_independent;
        wr_right && !wr_left && !clr_common_ev |=> $stable(o_left_speaker_volume);
    endproperty
    a_vol_independent: assert property (p_vol_independent) else $error("left volume disturbed");

    property p_vol_cleared;
        clr_common_ev |=> o_right_speaker_volume == VOL_RESET && o_left_speaker_volume == VOL_RESET
                          && o_clear_common;
    endproperty
    a_vol_cleared: assert property (p_vol_cleared) else $error("volume not cleared");

    property p_full_pulse;
        full_ev |=> o_clear_full_only && o_clear_common && o_applied_class == CLS_FULL;
    endproperty
    a_full_pulse: assert property (p_full_pulse) else $error("full class not applied");

    property p_soft_class;
        soft_ev && !full_ev |=> o_applied_class == CLS_SOFT && o_clear_common && !o_clear_full_only
                                ##1 o_system_power_on;
    endproperty
    a_soft_class: assert property (p_soft_class) else $error("soft class wrong");

    property p_retain_holds;
        retain_ev && !full_ev && !soft_ev && !poff_ev && !wr_en
            |=> !o_clear_common && $stable(o_right_speaker_volume) && $stable(o_left_speaker_volume);
    endproperty
    a_retain_holds: assert property (p_retain_holds) else $error("retention changed state");

    property p_poff_class;
        poff_ev && !full_ev && !soft_ev |=> o_applied_class == CLS_POFF && !o_system_power_on
                                            && o_clear_common && !o_clear_full_only;
    endproperty
    a_poff_class: assert property (p_poff_class) else $error("power-off class wrong");

    property p_full_only_map;
        o_clear_full_only |-> o_applied_class == CLS_FULL;
    endproperty
    a_full_only_map: assert property (p_full_only_map) else $error("full-only clear leaked");

    property p_common_map;
        o_clear_common == (o_applied_class == CLS_FULL || o_applied_class == CLS_SOFT
                           || o_applied_class == CLS_POFF);
    endproperty
    a_common_map: assert property (p_common_map) else $error("common clear mismatch");

    property p_priority;
        full_ev && (soft_ev || poff_ev || retain_ev) |=> o_applied_class == CLS_FULL;
    endproperty
    a_priority: assert property (p_priority) else $error("priority broken");

    property p_switch_edge;
        $rose(sw_sync[0]) && switch_reset_enable_bit && !full_ev
            |=> o_applied_class == CLS_SOFT ##1 !switch_reset_enable_bit;
    endproperty
    a_switch_edge: assert property (p_switch_edge) else $error("switch soft reset missed");

endmodule : vrd_top

// ---- vrd_top_tb.sv ----
// self-checking testbench for the speaker volume and reset-domain block
`timescale 1ns/1ns
module vrd_top_tb;
    import vrd_pkg::*;
    logic i_clk, i_rst_n, i_hard_reset_switch, i_reset_switch;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    logic [3:0]  i_wstrb;
    logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [7:0]  o_right_speaker_volume, o_left_speaker_volume;
    logic o_system_power_on, o_clear_full_only, o_clear_common;
    vrd_class_type o_applied_class, last_cls;
    int err_count, compares, n_cls, n_fo, n_com;
    logic [31:0] rd;
    logic [1:0]  rsp;
    typedef struct {
        logic [11:0] addr; logic [31:0] data; logic [3:0] strb;
        logic [1:0] resp; logic [7:0] exp_r; logic [7:0] exp_l;
    } vrd_row_type;
    vrd_row_type rows [6] = '{
        '{12'h340, 32'h0000_00FF, 4'hF, RESP_OKAY, 8'hFF, 8'h00},
        '{12'h344, 32'h0000_005A, 4'h1, RESP_OKAY, 8'hFF, 8'h5A},
        '{12'h340, 32'h0000_0000, 4'h1, RESP_OKAY, 8'h00, 8'h5A},
        '{12'h344, 32'hFFFF_FF81, 4'hF, RESP_OKAY, 8'h00, 8'h81},
        '{12'h340, 32'h0000_0033, 4'hE, RESP_OKAY, 8'h00, 8'h81},
        '{12'h348, 32'h0000_0077, 4'hF, RESP_SLVERR, 8'h00, 8'h81}};

    vrd_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hard_reset_switch(i_hard_reset_switch),
        .i_reset_switch(i_reset_switch), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_right_speaker_volume(o_right_speaker_volume),
        .o_left_speaker_volume(o_left_speaker_volume), .o_system_power_on(o_system_power_on),
        .o_clear_full_only(o_clear_full_only), .o_clear_common(o_clear_common),
        .o_applied_class(o_applied_class));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // pulses are counted so a double or missing pulse is seen, not only the last value
    always @(posedge i_clk) begin
        if (i_rst_n === 1'b1) begin
            if (o_applied_class !== CLS_NONE) begin
                last_cls = o_applied_class;
                n_cls++;
            end
            n_fo += (o_clear_full_only === 1'b1);
            n_com += (o_clear_common === 1'b1);
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic check_cls(input vrd_class_type exp, input int fo, input int com);
        check("class count", (exp == CLS_NONE) ? 0 : 1, n_cls);
        if (exp != CLS_NONE) check("applied class", {29'h0, exp}, {29'h0, last_cls});
        check("full-only pulses", fo, n_fo);
        check("common pulses", com, n_com);
    endtask : check_cls

    task automatic arm();
        @(negedge i_clk);
        n_cls = 0;
        n_fo = 0;
        n_com = 0;
    endtask : arm

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge i_clk);
        i_awaddr <= a; i_wdata <= d; i_wstrb <= s;
        i_awvalid <= 1'b1; i_wvalid <= 1'b1; i_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_clk);
            if (i_awvalid && o_awready === 1'b1) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready === 1'b1) i_wvalid <= 1'b0;
            if (o_bvalid === 1'b1) begin
                rsp = o_bresp;
                i_bready <= 1'b0;
                break;
            end
        end
        if (n == 100) check("write handshake", 1, 0);
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a);
        int n;
        @(posedge i_clk);
        i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_clk);
            if (i_arvalid && o_arready === 1'b1) i_arvalid <= 1'b0;
            if (o_rvalid === 1'b1) begin
                rd = o_rdata;
                rsp = o_rresp;
                i_rready <= 1'b0;
                break;
            end
        end
        if (n == 100) check("read handshake", 1, 0);
    endtask : axi_read

    task automatic set_vols(input logic [7:0] r, input logic [7:0] l);
        axi_write(VOL_RIGHT_ADDR, {24'h0, r}, 4'hF);
        axi_write(VOL_LEFT_ADDR, {24'h0, l}, 4'hF);
    endtask : set_vols

    task automatic check_vols(input logic [7:0] r, input logic [7:0] l);
        repeat (3) @(posedge i_clk);
        check("right volume", {24'h0, r}, {24'h0, o_right_speaker_volume});
        check("left volume", {24'h0, l}, {24'h0, o_left_speaker_volume});
        axi_read(VOL_RIGHT_ADDR);
        check("right readback", {24'h0, r}, rd);
        axi_read(VOL_LEFT_ADDR);
        check("left readback", {24'h0, l}, rd);
    endtask : check_vols

    task automatic press(input logic hard, input logic sw);
        @(posedge i_clk);
        i_hard_reset_switch <= hard;
        i_reset_switch <= sw;
        repeat (6) @(posedge i_clk);
        i_hard_reset_switch <= 1'b0;
        i_reset_switch <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask : press

    task automatic check_status(input vrd_class_type exp);
        axi_read(RSTSTAT_ADDR);
        check("status class", {29'h0, exp}, {29'h0, rd[2:0]});
    endtask : check_status

    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // the whole sequence needs a few hundred cycles, so this is a wide margin
    initial begin
        #200000;
        err_count++;
        stop_test();
    end

    initial begin
        i_rst_n = 1'b0; i_hard_reset_switch = 1'b0; i_reset_switch = 1'b0;
        i_awaddr = '0; i_wdata = '0; i_wstrb = '0; i_araddr = '0;
        i_awvalid = 1'b0; i_wvalid = 1'b0; i_bready = 1'b0; i_arvalid = 1'b0; i_rready = 1'b0;
        err_count = 0; compares = 0; last_cls = CLS_NONE;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        check_vols(8'h00, 8'h00);
        check_status(CLS_FULL);
        check("power bit", 1, {31'h0, o_system_power_on});
        foreach (rows[i]) begin
            axi_write(rows[i].addr, rows[i].data, rows[i].strb);
            check("write resp", {30'h0, rows[i].resp}, {30'h0, rsp});
            check_vols(rows[i].exp_r, rows[i].exp_l);
        end
        axi_read(12'h3FC);
        check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        check("unmapped data", 32'h0000_0000, rd);
        axi_read(VOL_LEFT_ADDR);
        check("read resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        set_vols(8'h11, 8'h22);
        arm();
        axi_write(RSTCTL_ADDR, 32'h0000_0001, 4'hF);
        check_vols(8'h00, 8'h00);
        check_cls(CLS_SOFT, 0, 1);
        set_vols(8'h33, 8'h44);
        axi_write(RSTCTL_ADDR, 32'h0000_0002, 4'hF);
        axi_read(RSTCTL_ADDR);
        check("switch enable readback", 32'h0000_0002, rd);
        arm();
        press(1'b0, 1'b1);
        check_cls(CLS_SOFT, 0, 1);
        check_vols(8'h00, 8'h00);
        set_vols(8'h55, 8'h66);
        arm();
        press(1'b0, 1'b1);
        check_cls(CLS_RETAIN, 0, 0);
        check_vols(8'h55, 8'h66);
        check_status(CLS_RETAIN);
        arm();
        axi_write(SYSPWR_ADDR, 32'h0000_0000, 4'hF);
        check_vols(8'h00, 8'h00);
        check_cls(CLS_POFF, 0, 1);
        check("power bit", 0, {31'h0, o_system_power_on});
        arm();
        axi_write(SYSPWR_ADDR, 32'h0000_0000, 4'hF);
        axi_write(SYSPWR_ADDR, 32'h0000_0001, 4'hF);
        repeat (3) @(posedge i_clk);
        check_cls(CLS_NONE, 0, 0);
        check("power bit", 1, {31'h0, o_system_power_on});
        set_vols(8'h77, 8'h88);
        arm();
        press(1'b1, 1'b0);
        check_cls(CLS_FULL, 1, 1);
        check_vols(8'h00, 8'h00);
        // simultaneous full and soft requests: only the full class may appear
        axi_write(RSTCTL_ADDR, 32'h0000_0002, 4'hF);
        set_vols(8'h99, 8'hAA);
        arm();
        press(1'b1, 1'b1);
        check_cls(CLS_FULL, 1, 1);
        check_status(CLS_FULL);
        check_vols(8'h00, 8'h00);
        set_vols(8'hBB, 8'hCC);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        // bus is frozen in reset, so only the pins are looked at here
        check("right volume in reset", 32'h0000_0000, {24'h0, o_right_speaker_volume});
        check("left volume in reset", 32'h0000_0000, {24'h0, o_left_speaker_volume});
        check("class in reset", {29'h0, CLS_FULL}, {29'h0, o_applied_class});
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        check("class after release", {29'h0, CLS_NONE}, {29'h0, o_applied_class});
        check_vols(8'h00, 8'h00);
        check_status(CLS_FULL);
        stop_test();
    end
endmodule : vrd_top_tb
